// ==== logic/arp_pkg.sv ====
// Shared constants, types and timing counts for the result output port
package arp_pkg;

  // ==========================================================
  // Result word and code format
  localparam int RESULT_BITS = 16;
  localparam logic [15:0] CODE_MSB_FLIP = 16'h8000;
  localparam logic [15:0] OUT_RESET = 16'h0000;
  localparam logic [3:0] BIT_LAST = 4'hF;
  localparam int BYTE_HI_POS = 8;

  // ==========================================================
  // Timing at the core clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS = 2200;
  localparam int CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] CONV_LAST = 6'(CONV_CYCLES - 1);
  localparam int BUSY_RISE_NS = 90;
  localparam int BUSY_RISE_CYCLES =
    (BUSY_RISE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] BUSY_RISE_LAST = 6'(BUSY_RISE_CYCLES - 1);

  // ==========================================================
  // Internal shift clock, about 900 kHz
  localparam int DCLK_RATE_KHZ = 900;
  localparam int DCLK_PERIOD_CYCLES =
    1000000 / (DCLK_RATE_KHZ * CLK_PERIOD_NS);
  localparam logic [4:0] DCLK_LAST = 5'(DCLK_PERIOD_CYCLES - 1);
  localparam logic [4:0] DCLK_RISE_AT = 5'(DCLK_PERIOD_CYCLES / 4);
  localparam logic [4:0] DCLK_FALL_AT =
    5'(DCLK_PERIOD_CYCLES / 4 + DCLK_PERIOD_CYCLES / 2);

  // ==========================================================
  // Types
  typedef struct packed {
    logic cs_n;
    logic read_convert;
    logic byte_select;
    logic code_format_select;
    logic clock_source_select;
    logic shift_clock;
    logic daisy_chain;
  } arp_pins_type;

  localparam int PIN_BITS = $bits(arp_pins_type);
  // Idle pin levels; an all-zero reset would read as a convert command
  localparam logic [PIN_BITS-1:0] PINS_IDLE = 7'h64;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_FINISH,
    ST_RISE
  } arp_state_type;

endpackage

// ==== logic/arp_sync2.sv ====
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module arp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ==========================================================
  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== logic/arp_result_port.sv ====
// Result output port of a 16-bit converter: format, parallel and serial
`timescale 1ns/1ps
// What this block does
// - Format select high gives straight binary, low gives two's complement.
// - Codes are the core code as is, or with the top bit flipped.
// - First conversion after reset is flagged as not valid.
// - Parallel reads keep the output register; each serial pulse but the first external one after select shifts it.
// - Parallel pins driven only with chip select low and read high.
// - Byte select low gives upper byte, high gives lower byte.
// - Output register holds no meaningful value until a conversion loads it.
// - Busy returns high only after the output register was updated.
// - Previous result stays put during conversion in external mode; internal mode shifts it out. Host waits for busy.
// - Busy drops at once when a conversion start is seen.
// - Busy rises a fixed short delay after the load, which waits for any internal transfer to end.
// - Serial output is always driven.
// - Internal mode start also runs the internal shift clock out.
// - Internal mode sends previous result, MSB first, sixteen pulses.
// - In internal mode, each serial bit is steady across both edges of its pulse.
// - After sixteen pulses clock stays low, output shows latched chain bit.
// - External mode still converts on the internal timing.
// - External mode read shifts out whatever the output register holds.
// - Start seen as busy rises runs without acquisition, data invalid.
// - Start commands while busy are ignored.
// - Chain input lets several converters form one serial stream.
// - In external mode, after sixteen bits, chain input bits follow, one per clock.
module arp_result_port
  import arp_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic code_format_select,
  input wire logic clock_source_select,
  input wire logic serial_shift_clock_in,
  input wire logic daisy_chain_in,
  input wire logic [15:0] analog_code,
  output logic [7:0] parallel_result_pins,
  output logic parallel_result_oe,
  output logic serial_shift_clock_out,
  output logic serial_shift_clock_oe,
  output logic serial_result_out,
  output logic conv_busy_n,
  output logic result_valid
);

  // ==========================================================
  // Pin synchronisation
  arp_pins_type pins_raw;
  arp_pins_type pins_s;

  assign pins_raw = arp_pins_type'({cs_n, read_convert, byte_select,
    code_format_select, clock_source_select, serial_shift_clock_in,
    daisy_chain_in});

  arp_sync2 #(
    .WIDTH(PIN_BITS),
    .INIT(PINS_IDLE)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic start_req;
  logic read_sel;
  logic ext_mode;
  logic ext_rise;
  logic shift_clock_prev_reg;
  logic read_sel_prev_reg;

  // Select lines are level-sensitive, so no edge is needed to start
  assign start_req = ~pins_s.cs_n & ~pins_s.read_convert;
  assign read_sel = ~pins_s.cs_n & pins_s.read_convert;
  assign ext_mode = pins_s.clock_source_select;
  assign ext_rise = pins_s.shift_clock & ~shift_clock_prev_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      shift_clock_prev_reg <= 1'b0;
      read_sel_prev_reg <= 1'b0;
    end else begin
      shift_clock_prev_reg <= pins_s.shift_clock;
      read_sel_prev_reg <= read_sel;
    end
  end

  // ==========================================================
  // Conversion sequencer
  arp_state_type state_reg;
  logic [5:0] conv_cnt_reg;
  logic tx_active_reg;
  logic start_ok;
  logic load;

  assign start_ok = (state_reg == ST_IDLE) & start_req;
  assign load = (state_reg == ST_FINISH) & ~tx_active_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      conv_cnt_reg <= 6'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_CONVERT;
            conv_cnt_reg <= 6'h00;
          end
        end
        ST_CONVERT: begin
          // Same timing in both clock modes
          if (conv_cnt_reg == CONV_LAST) begin
            state_reg <= ST_FINISH;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 6'h01;
          end
        end
        ST_FINISH: begin
          // Held until the internal transfer drains the old result
          if (!tx_active_reg) begin
            state_reg <= ST_RISE;
            conv_cnt_reg <= 6'h00;
          end
        end
        ST_RISE: begin
          if (conv_cnt_reg == BUSY_RISE_LAST) begin
            state_reg <= ST_IDLE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg + 6'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Busy flag
  always_ff @(posedge clock) begin
    if (reset) begin
      conv_busy_n <= 1'b1;
    end else if (start_ok) begin
      conv_busy_n <= 1'b0;
    end else if (state_reg == ST_RISE && conv_cnt_reg == BUSY_RISE_LAST) begin
      conv_busy_n <= 1'b1;
    end
  end

  // ==========================================================
  // Sample capture and validity
  logic [15:0] sample_reg;
  logic acquired_reg;
  logic first_done_reg;
  logic just_idle_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      just_idle_reg <= 1'b0;
    end else begin
      just_idle_reg <= (state_reg == ST_RISE) &&
        (conv_cnt_reg == BUSY_RISE_LAST);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sample_reg <= OUT_RESET;
      acquired_reg <= 1'b0;
    end else if (start_ok) begin
      sample_reg <= analog_code;
      // Start already pending as busy rose: no track time
      acquired_reg <= ~just_idle_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      first_done_reg <= 1'b0;
      result_valid <= 1'b0;
    end else if (load) begin
      first_done_reg <= 1'b1;
      result_valid <= acquired_reg & first_done_reg;
    end
  end

  // ==========================================================
  // Internal shift clock transfer
  logic [4:0] phase_reg;
  logic [3:0] bit_cnt_reg;
  logic tag_latched_reg;
  logic int_shift;

  assign int_shift = tx_active_reg & (phase_reg == DCLK_LAST);

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_active_reg <= 1'b0;
      phase_reg <= 5'h00;
      bit_cnt_reg <= 4'h0;
      tag_latched_reg <= 1'b0;
    end else if (start_ok && !ext_mode) begin
      tx_active_reg <= 1'b1;
      phase_reg <= 5'h00;
      bit_cnt_reg <= 4'h0;
      tag_latched_reg <= pins_s.daisy_chain;
    end else if (tx_active_reg) begin
      if (phase_reg == DCLK_LAST) begin
        phase_reg <= 5'h00;
        if (bit_cnt_reg == BIT_LAST) begin
          tx_active_reg <= 1'b0;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else begin
        phase_reg <= phase_reg + 5'h01;
      end
    end
  end

  // Shift lands mid-low phase, well clear of both edges
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_shift_clock_out <= 1'b0;
      serial_shift_clock_oe <= 1'b0;
    end else begin
      serial_shift_clock_out <= tx_active_reg &&
        (phase_reg >= DCLK_RISE_AT) && (phase_reg < DCLK_FALL_AT);
      serial_shift_clock_oe <= ~ext_mode;
    end
  end

  // ==========================================================
  // External shift clock reads
  logic skip_reg;
  logic ext_shift;

  // Host keeps the pin low in parallel use, so no edges arrive
  assign ext_shift = ext_mode & read_sel & ext_rise & ~skip_reg;

  // First rising edge after select only presents the MSB
  always_ff @(posedge clock) begin
    if (reset) begin
      skip_reg <= 1'b1;
    end else if (read_sel && !read_sel_prev_reg) begin
      skip_reg <= 1'b1;
    end else if (ext_mode && read_sel && ext_rise) begin
      skip_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Output register
  logic [15:0] out_reg;
  logic [15:0] formatted;

  assign formatted = pins_s.code_format_select ?
    (sample_reg ^ CODE_MSB_FLIP) : sample_reg;

  // Only a load or a shift touches it; no parallel read does
  always_ff @(posedge clock) begin
    if (reset) begin
      out_reg <= OUT_RESET;
    end else if (load) begin
      out_reg <= formatted;
    end else if (int_shift) begin
      out_reg <= {out_reg[14:0], tag_latched_reg};
    end else if (ext_shift) begin
      out_reg <= {out_reg[14:0], pins_s.daisy_chain};
    end
  end

  assign serial_result_out = out_reg[15];

  // ==========================================================
  // Parallel byte port
  always_ff @(posedge clock) begin
    if (reset) begin
      parallel_result_pins <= 8'h00;
      parallel_result_oe <= 1'b0;
    end else begin
      parallel_result_oe <= read_sel;
      if (pins_s.byte_select) begin
        parallel_result_pins <= out_reg[7:0];
      end else begin
        parallel_result_pins <= out_reg[15:BYTE_HI_POS];
      end
    end
  end

  // ==========================================================
  // Checks
  logic [4:0] pulse_cnt_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      pulse_cnt_reg <= 5'h00;
    end else if (start_ok && !ext_mode) begin
      pulse_cnt_reg <= 5'h00;
    end else if (int_shift) begin
      pulse_cnt_reg <= pulse_cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_start;
    start_ok;
  endsequence

  sequence s_conv_run;
    ##44 (state_reg == ST_CONVERT) ##1 (state_reg == ST_FINISH);
  endsequence

  sequence s_busy_rise;
    !conv_busy_n ##1 conv_busy_n;
  endsequence

  AST_FORMAT_LOAD: assert property (load |=> out_reg ==
    ($past(pins_s.code_format_select) ?
     ($past(sample_reg) ^ CODE_MSB_FLIP) : $past(sample_reg)))
    else $error("Output register loaded in the wrong code format");

  AST_PAR_OE: assert property (read_sel != parallel_result_oe
    |=> parallel_result_oe == $past(read_sel))
    else $error("Parallel enable does not follow the select lines");

  AST_BYTE_MUX: assert property (##1 parallel_result_pins ==
    ($past(pins_s.byte_select) ? $past(out_reg[7:0]) :
     $past(out_reg[15:8])))
    else $error("Wrong byte on the parallel pins");

  AST_NO_SHIFT: assert property (!load && !int_shift && !ext_shift
    |=> $stable(out_reg))
    else $error("Output register changed without load or shift");
  AST_BUSY_FALL: assert property (s_start |=> !conv_busy_n)
    else $error("Busy did not drop after a start");
  AST_BUSY_RISE: assert property (load |-> ##2 s_busy_rise)
    else $error("Busy did not rise two cycles after the load");
  AST_IGNORE_BUSY: assert property (!conv_busy_n &&
    state_reg != ST_RISE |=> !conv_busy_n && state_reg != ST_IDLE)
    else $error("Start command accepted while busy");
  AST_CONV_LEN: assert property (s_start |-> s_conv_run)
    else $error("Conversion length is wrong");
  AST_INT_PULSES: assert property ($fell(tx_active_reg)
    |-> pulse_cnt_reg == 5'h10)
    else $error("Internal transfer did not give sixteen pulses");
  AST_STABLE_EDGES: assert property (tx_active_reg &&
    $changed(serial_shift_clock_out) |-> $stable(out_reg))
    else $error("Serial bit changed at a shift clock edge");
  AST_TAG_FILL: assert property ($fell(tx_active_reg)
    |-> out_reg == {16{tag_latched_reg}} && !serial_shift_clock_out)
    else $error("Serial output does not show the latched chain bit");
  AST_FIRST_INVALID: assert property (load && !first_done_reg
    |=> !result_valid)
    else $error("First conversion marked valid");

endmodule

// ==== tb/arp_host_model.sv ====
// Host model: external shift clock, chain bits and serial capture
`timescale 1ns/1ps
module arp_host_model (
  output logic shift_clock,
  output logic chain,
  input wire logic serial_data
);
  logic got[$];

  // ====================================
  // Idle levels
  initial begin
    shift_clock = 1'b0;
    chain = 1'b0;
  end

  // ====================================
  // Frame of n pulses, 400 ns period
  // Clock stands still low between frames; offset keeps it off core edges
  task automatic shift(input int n);
    got.delete();
    #37;
    for (int k = 1; k <= n; k++) begin
      chain = k[1];
      #200;
      shift_clock = 1'b1;
      #200;
      got.push_back(serial_data);
      shift_clock = 1'b0;
    end
  endtask
endmodule

// ==== tb/arp_result_port_test.sv ====
// Self-checking bench for the result output port
`timescale 1ns/1ps
module arp_result_port_test;
  import arp_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cs_n = 1'b1;
  logic read_convert = 1'b1;
  logic byte_select = 1'b0;
  logic fmt_sel = 1'b0;
  logic src_sel = 1'b1;
  logic [15:0] analog_code = 16'h0000;
  logic shift_host, shift_pin, chain_in;
  logic [7:0] pins;
  logic pins_oe, clk_out, clk_oe, sdo, busy_n, valid;
  logic clk_out_d = 1'b0;
  logic [15:0] prev = OUT_RESET;
  logic prev_ok = 1'b0;
  logic [15:0] codes [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  logic [15:0] sb_codes [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
  logic int_bits[$];
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  // ====================================
  // Clock, shared shift clock wire, instances
  always #25 clock = ~clock;
  assign shift_pin = clk_oe ? clk_out : shift_host;

  arp_result_port u_dut (
    .clock(clock), .reset(reset), .cs_n(cs_n),
    .read_convert(read_convert), .byte_select(byte_select),
    .code_format_select(fmt_sel), .clock_source_select(src_sel),
    .serial_shift_clock_in(shift_pin), .daisy_chain_in(chain_in),
    .analog_code(analog_code), .parallel_result_pins(pins),
    .parallel_result_oe(pins_oe), .serial_shift_clock_out(clk_out),
    .serial_shift_clock_oe(clk_oe), .serial_result_out(sdo),
    .conv_busy_n(busy_n), .result_valid(valid)
  );

  arp_host_model u_host (
    .shift_clock(shift_host), .chain(chain_in), .serial_data(sdo)
  );

  // ====================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy_n !== lvl && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
  endtask

  // Hold keeps both controls low across the whole conversion
  task automatic convert(input logic [15:0] code, input logic fmt,
      input logic src, input logic hold, output int low);
    int n;
    logic [15:0] want;
    want = fmt ? (code ^ 16'h8000) : code;
    @(posedge clock);
    analog_code <= code;
    fmt_sel <= fmt;
    src_sel <= src;
    byte_select <= 1'b0;
    cs_n <= 1'b0;
    read_convert <= 1'b0;
    wait_busy(1'b0, 10, n);
    check(16'(n), 16'h0003);
    @(posedge clock);
    read_convert <= ~hold;
    tick(8);
    if (src && !hold && prev_ok) begin
      check({8'h00, pins}, {8'h00, prev[15:8]});
    end
    wait_busy(1'b1, 800, low);
    if (!hold) begin
      check({8'h00, pins}, {8'h00, want[15:8]});
    end else begin
      wait_busy(1'b0, 6, n);
      check(16'(n < 6), 16'h0001);
      @(posedge clock);
      read_convert <= 1'b1;
      wait_busy(1'b1, 800, n);
      check(16'(valid), 16'h0000);
    end
    @(posedge clock);
    cs_n <= 1'b1;
    read_convert <= 1'b1;
    prev = want;
    prev_ok = ~hold;
  endtask

  task automatic read_par(output logic [15:0] v);
    @(posedge clock);
    cs_n <= 1'b0;
    read_convert <= 1'b1;
    byte_select <= 1'b0;
    tick(4);
    check(16'(pins_oe), 16'h0001);
    v[15:8] = pins;
    byte_select <= 1'b1;
    tick(4);
    v[7:0] = pins;
    cs_n <= 1'b1;
    byte_select <= 1'b0;
    tick(4);
    check(16'(pins_oe), 16'h0000);
  endtask

  // ====================================
  // Internal frame capture and hang guard
  always @(posedge clock) begin
    clk_out_d <= clk_out;
    if (clk_out && !clk_out_d) begin
      int_bits.push_back(sdo);
      check(16'(clk_oe), 16'h0001);
    end
    if (!clk_out && clk_out_d) begin
      check(16'(sdo), 16'(int_bits[$]));
    end
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ====================================
  // Tests
  initial begin
    logic [15:0] v;
    logic [15:0] m;
    int low1;
    int low2;
    tick(16);
    reset <= 1'b0;
    tick(4);
    check({12'h000, busy_n, valid, pins_oe, clk_oe}, 16'h0008);
    convert(16'h7FFF, 1'b0, 1'b1, 1'b0, low1);
    check(16'(valid), 16'h0000);
    read_par(v);
    check(v, 16'h7FFF);
    read_par(v);
    check(v, 16'h7FFF);
    $display("test first conversion done");
    for (int i = 0; i < 8; i++) begin
      convert(codes[i % 4], i[2], 1'b1, 1'b0, low2);
      check(16'(valid), 16'h0001);
      read_par(v);
      check(v, i[2] ? sb_codes[i % 4] : codes[i % 4]);
    end
    $display("test code formats done");
    convert(16'h1234, 1'b0, 1'b1, 1'b1, low2);
    check(16'(low2), 16'(low1));
    $display("test held convert done");
    convert(16'hA5C3, 1'b0, 1'b1, 1'b0, low2);
    read_par(v);
    check(v, 16'hA5C3);
    @(posedge clock);
    cs_n <= 1'b0;
    tick(4);
    u_host.shift(18);
    m = 16'hA5C3;
    for (int k = 1; k <= 18; k++) begin
      if (k > 1) m = {m[14:0], k[1]};
      check(16'(u_host.got[k-1]), 16'(m[15]));
    end
    @(posedge clock);
    cs_n <= 1'b1;
    tick(4);
    read_par(v);
    check(v, m);
    $display("test external serial done");
    int_bits.delete();
    convert(16'h0F0F, 1'b0, 1'b0, 1'b0, low2);
    tick(30);
    check(16'(int_bits.size()), 16'h0010);
    for (int k = 0; k < 16; k++) begin
      check(16'(int_bits[k]), 16'(m[15-k]));
    end
    read_par(v);
    check(v, 16'h0F0F);
    $display("test internal serial done");
    tally_and_finish();
  end
endmodule
